// >>> rtl/dsl_strap_lane_cfg.sv
// Purpose: Strap decode, lane mode selection and register file of the deserializer
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses, one wait state
// Notes:   Outputs are registered copies of the settings listed below
// Overview of operation
// - Each strap input decodes to one of eight levels, each a fixed setting set.
// - Low strap levels 1-4 map select 0, 5-8 give 1; output config steps 00..11.
// - Output config 00 dual, 01 dual swapped, 10 single, 11 replicate.
// - High strap levels 1-4 repeater 0, 5-8 give 1; mode field steps 00..11.
// - Mode 00 5M pair, 01 5M coax, 10 20M pair, 11 20M coax.
// - Map select 0 puts least significant colour bits on D3 and D7.
// - Without override, receiver follows detected one-lane or two-lane link.
// - Writing override register bits 4:3 fixes the input lane configuration.
// - Only seven lane and display pairings; no replicate on one lane.
// - Override value 10 gives one-lane input with single-link display output.
// - Decoded straps latch into configuration registers, readable and writable.
`timescale 1ns/1ns
module dsl_strap_lane_cfg
	import dsl_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic [2:0]  strap_select_low,
	input  wire logic [2:0]  strap_select_high,
	input  wire logic        lane_active_pin,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             bit_map_select,
	output logic             lsb_on_d3_d7,
	output logic             disp_dual,
	output logic             disp_swap,
	output logic             disp_replicate,
	output logic             repeater_en,
	output logic             back_channel_fast,
	output logic             cable_coax,
	output logic             rx_two_lane,
	output logic             config_valid
);
	// ==========================================================
	// State
	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
		logic [5:0]  cfg;
		logic [7:0]  ovr;
		logic        ovr_on;
		logic        lo_ok;
		logic        hi_ok;
		logic        map;
		logic        lsb;
		logic        dual;
		logic        swap;
		logic        repl;
		logic        rpt;
		logic        fast;
		logic        coax;
		logic        two;
		logic        valid;
	} dsl_top_s;

	dsl_top_s    st;
	dsl_top_s    nx;
	logic [2:0]  lo_lvl;
	logic [2:0]  hi_lvl;
	logic        lo_pulse;
	logic        hi_pulse;
	logic        det_two;
	logic        req;
	logic        hit_cfg;
	logic        hit_sts;
	logic        hit_ovr;
	logic        two_eff;
	logic        one_single;
	dsl_out_e    olc;
	dsl_out_e    olc_eff;
	dsl_lane_e   lane;
	logic [7:0]  status;

	// ==========================================================
	// Strap capture and lane detection
	dsl_strap_sample u_strap_low (
		.clk_sys    (clk_sys),
		.sys_rst    (sys_rst),
		.level_pin  (strap_select_low),
		.level      (lo_lvl),
		.load_pulse (lo_pulse)
	);

	dsl_strap_sample u_strap_high (
		.clk_sys    (clk_sys),
		.sys_rst    (sys_rst),
		.level_pin  (strap_select_high),
		.level      (hi_lvl),
		.load_pulse (hi_pulse)
	);

	dsl_lane_detect u_lane_det (
		.clk_sys         (clk_sys),
		.sys_rst         (sys_rst),
		.lane_active_pin (lane_active_pin),
		.two_lane        (det_two)
	);

	// ==========================================================
	// Next state
	always_comb
	begin
		nx      = st;
		nx.ack  = 1'b0;
		req     = wb_cyc_i && wb_stb_i && !st.ack;
		hit_cfg = 1'b0;
		hit_sts = 1'b0;
		hit_ovr = 1'b0;
		status  = {st.ovr_on, st.repl, st.swap, st.dual, st.two, det_two,
			st.hi_ok, st.lo_ok};
		if (wb_adr_i[7:2] == ADR_STRAP_CFG[7:2])
			hit_cfg = 1'b1;
		else if (wb_adr_i[7:2] == ADR_STATUS[7:2])
			hit_sts = 1'b1;
		else if (wb_adr_i[7:2] == ADR_LANE_OVR[7:2])
			hit_ovr = 1'b1;
		if (req)
		begin
			nx.ack   = 1'b1;
			nx.rdata = 32'h0000_0000;
			if (hit_cfg)
				nx.rdata = {26'h0, st.cfg};
			else if (hit_sts)
				nx.rdata = {24'h0, status};
			else if (hit_ovr)
				nx.rdata = {24'h0, st.ovr};
			if (wb_we_i && wb_sel_i[0])
			begin
				if (hit_cfg)
					nx.cfg = wb_dat_i[5:0];
				else if (hit_ovr)
				begin
					nx.ovr    = wb_dat_i[7:0];
					nx.ovr_on = 1'b1;
				end
			end
		end
		if (lo_pulse)
		begin
			nx.cfg[CFG_MAP_BIT] = lo_lvl[LVL_GROUP_BIT];
			nx.cfg[CFG_OLC_LSB +: 2] = lo_lvl[1:0];
			nx.lo_ok = 1'b1;
		end
		if (hi_pulse)
		begin
			nx.cfg[CFG_RPT_BIT] = hi_lvl[LVL_GROUP_BIT];
			nx.cfg[CFG_MODE_LSB +: 2] = hi_lvl[1:0];
			nx.hi_ok = 1'b1;
		end

		// Effective lane and display pairing
		olc  = dsl_out_e'(nx.cfg[CFG_OLC_LSB +: 2]);
		lane = dsl_lane_e'(nx.ovr[OVR_LANE_LSB +: 2]);
		if (!nx.ovr_on)
		begin
			two_eff    = det_two;
			one_single = 1'b0;
		end
		else
		begin
			two_eff    = (lane == DSL_LN_TWO) || (lane == DSL_LN_TWO_SINGLE);
			one_single = (lane == DSL_LN_ONE_SINGLE) || (lane == DSL_LN_TWO_SINGLE);
		end
		if (one_single)
			olc_eff = DSL_OUT_SINGLE;
		else if (!two_eff && olc == DSL_OUT_REPL)
			olc_eff = DSL_OUT_SINGLE;
		else
			olc_eff = olc;
		nx.two  = two_eff;
		nx.dual = (olc_eff == DSL_OUT_DUAL) || (olc_eff == DSL_OUT_SWAP);
		nx.swap = olc_eff == DSL_OUT_SWAP;
		nx.repl = olc_eff == DSL_OUT_REPL;
		nx.map  = nx.cfg[CFG_MAP_BIT];
		nx.lsb  = !nx.cfg[CFG_MAP_BIT];
		nx.rpt  = nx.cfg[CFG_RPT_BIT];
		nx.fast = nx.cfg[CFG_MODE_LSB + 1];
		nx.coax = nx.cfg[CFG_MODE_LSB];
		nx.valid = nx.lo_ok && nx.hi_ok;
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_sys)
		if (sys_rst)
		begin
			st     <= '0;
			st.cfg <= STRAP_CFG_RST;
			st.ovr <= LANE_OVR_RST;
			st.lsb <= !STRAP_CFG_RST[CFG_MAP_BIT];
		end
		else
			st <= nx;

	assign wb_dat_o          = st.rdata;
	assign wb_ack_o          = st.ack;
	assign bit_map_select    = st.map;
	assign lsb_on_d3_d7      = st.lsb;
	assign disp_dual         = st.dual;
	assign disp_swap         = st.swap;
	assign disp_replicate    = st.repl;
	assign repeater_en       = st.rpt;
	assign back_channel_fast = st.fast;
	assign cable_coax        = st.coax;
	assign rx_two_lane       = st.two;
	assign config_valid      = st.valid;

	// ==========================================================
	// Checks
	default clocking dsl_cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	sequence lo_load_s;
		lo_pulse;
	endsequence

	sequence hi_load_s;
		hi_pulse;
	endsequence

	sequence ovr_wr_s;
		req && wb_we_i && wb_sel_i[0] && hit_ovr && !lo_pulse && !hi_pulse;
	endsequence

	sequence quiet_s;
		!(req && wb_we_i) && !lo_pulse && !hi_pulse;
	endsequence

	sequence cfg_rd_s;
		req && !wb_we_i && hit_cfg;
	endsequence

	sequence ovr_rd_s;
		req && !wb_we_i && hit_ovr;
	endsequence

	sequence cfg_wr_s;
		req && wb_we_i && wb_sel_i[0] && hit_cfg && !lo_pulse && !hi_pulse;
	endsequence

	low_decode_a: assert property (
		lo_load_s |=> (bit_map_select == $past(lo_lvl[2]))
			&& (st.cfg[CFG_OLC_LSB +: 2] == $past(lo_lvl[1:0])))
		else $error("low strap decode wrong");

	high_decode_a: assert property (
		hi_load_s |=> (repeater_en == $past(hi_lvl[2]))
			&& (back_channel_fast == $past(hi_lvl[1])) && (cable_coax == $past(hi_lvl[0])))
		else $error("high strap decode wrong");

	back_channel_a: assert property (
		{back_channel_fast, cable_coax} == st.cfg[CFG_MODE_LSB +: 2])
		else $error("back channel mode mismatch");

	lsb_lane_a: assert property (
		lsb_on_d3_d7 != bit_map_select)
		else $error("lsb placement not inverse of map select");

	disp_mode_a: assert property (
		(!st.ovr_on && st.cfg[CFG_OLC_LSB +: 2] == 2'h1) |-> disp_dual && disp_swap
			&& !disp_replicate)
		else $error("swapped dual output not selected");

	auto_lane_a: assert property (
		(!st.ovr_on && !$past(st.ovr_on) && !$past(sys_rst)) |-> rx_two_lane == $past(det_two))
		else $error("lane mode does not follow detection");

	ovr_write_a: assert property (
		ovr_wr_s |=> wb_ack_o && st.ovr_on
			&& (st.ovr[OVR_LANE_LSB +: 2] == $past(wb_dat_i[4:3])))
		else $error("override write not taken");

	pairing_a: assert property (
		!(disp_replicate && !rx_two_lane))
		else $error("replicate output on one lane");

	one_single_a: assert property (
		(st.ovr_on && st.ovr[OVR_LANE_LSB +: 2] == 2'h2) |-> !rx_two_lane && !disp_dual
			&& !disp_replicate)
		else $error("override 10 not one lane single");

	strap_hold_a: assert property (
		quiet_s |=> $stable(st.cfg))
		else $error("config changed without cause");

	ack_pulse_a: assert property (
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single cycle");

	cfg_read_a: assert property (
		cfg_rd_s |=> wb_ack_o && (wb_dat_o == {26'h0, $past(st.cfg)}))
		else $error("config read data wrong");

	cfg_write_a: assert property (
		cfg_wr_s |=> st.cfg == $past(wb_dat_i[5:0]))
		else $error("config write not taken");

	ovr_read_a: assert property (
		ovr_rd_s |=> wb_dat_o == {24'h0, $past(st.ovr)})
		else $error("override read data wrong");

	unmapped_rd_a: assert property (
		(req && !wb_we_i && !hit_cfg && !hit_sts && !hit_ovr) |=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");

	low_once_a: assert property (
		st.lo_ok |-> !lo_pulse)
		else $error("low strap sampled twice");

	high_once_a: assert property (
		st.hi_ok |-> !hi_pulse)
		else $error("high strap sampled twice");

	valid_hold_a: assert property (
		config_valid |=> config_valid)
		else $error("config valid dropped");

	ovr_sticky_a: assert property (
		st.ovr_on |=> st.ovr_on)
		else $error("override released");

	ovr_lane_a: assert property (
		st.ovr_on |-> rx_two_lane == (st.ovr[OVR_LANE_LSB] == st.ovr[OVR_LANE_LSB + 1]))
		else $error("override lane mode wrong");

	swap_dual_a: assert property (
		disp_swap |-> disp_dual && !disp_replicate)
		else $error("swapped output not dual");

	repl_cfg_a: assert property (
		disp_replicate |-> !disp_dual && (st.cfg[CFG_OLC_LSB +: 2] == 2'h3))
		else $error("replicate without replicate setting");

	single_out_a: assert property (
		(st.cfg[CFG_OLC_LSB +: 2] == 2'h2) |-> !disp_dual && !disp_replicate)
		else $error("single output setting not single");
endmodule // dsl_strap_lane_cfg

// >>> rtl/dsl_pkg.sv
// Purpose: Shared constants and types of the strap and lane configuration block
// Assumes: 250 MHz system clock, byte addresses on the register bus
// Notes:   Strap levels are 3-bit codes, code 0 is level 1 and code 7 is level 8
package dsl_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS    = 4;
	localparam int STRAP_SETTLE_NS  = 64;
	localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LANE_STABLE_NS   = 40;
	localparam int LANE_STABLE_CYC  = (LANE_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Register map
	localparam logic [7:0] ADR_STRAP_CFG = 8'h00;
	localparam logic [7:0] ADR_STATUS    = 8'h04;
	localparam logic [7:0] ADR_LANE_OVR  = 8'h34;
	localparam logic [5:0] STRAP_CFG_RST = 6'h00;
	localparam logic [7:0] LANE_OVR_RST  = 8'h00;

	// ==========================================================
	// Field positions
	localparam int CFG_MAP_BIT   = 0;
	localparam int CFG_OLC_LSB   = 1;
	localparam int CFG_RPT_BIT   = 3;
	localparam int CFG_MODE_LSB  = 4;
	localparam int OVR_LANE_LSB  = 3;
	localparam int LVL_GROUP_BIT = 2;

	// ==========================================================
	// Encodings
	typedef enum logic [1:0] {
		DSL_OUT_DUAL   = 2'b00,
		DSL_OUT_SWAP   = 2'b01,
		DSL_OUT_SINGLE = 2'b10,
		DSL_OUT_REPL   = 2'b11
	} dsl_out_e;

	typedef enum logic [1:0] {
		DSL_LN_TWO        = 2'b00,
		DSL_LN_ONE        = 2'b01,
		DSL_LN_ONE_SINGLE = 2'b10,
		DSL_LN_TWO_SINGLE = 2'b11
	} dsl_lane_e;

	typedef enum logic [1:0] {
		DSL_SMP_SETTLE = 2'b00,
		DSL_SMP_HOLD   = 2'b01
	} dsl_smp_e;
endpackage

// >>> rtl/dsl_strap_sample.sv
// Purpose: Synchronise one strap level code and capture it once after reset
// Assumes: Strap pins are static while the part runs
// Notes:   Level is held until the next reset
`timescale 1ns/1ns
module dsl_strap_sample
	import dsl_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic [2:0] level_pin,
	output logic      [2:0] level,
	output logic            load_pulse
);
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [7:0] cnt;
		dsl_smp_e   state;
		logic [2:0] level;
		logic       load;
	} dsl_smp_s;

	dsl_smp_s st;
	dsl_smp_s nx;

	always_comb
	begin
		nx      = st;
		nx.s1   = level_pin;
		nx.s2   = st.s1;
		nx.load = 1'b0;
		case (st.state)
			DSL_SMP_SETTLE:
			begin
				if (st.cnt == 8'(STRAP_SETTLE_CYC - 1))
				begin
					nx.level = st.s2;
					nx.load  = 1'b1;
					nx.state = DSL_SMP_HOLD;
				end
				else
					nx.cnt = st.cnt + 8'h01;
			end
			default: nx.state = DSL_SMP_HOLD;
		endcase
	end

	always_ff @(posedge clk_sys)
		if (sys_rst)
			st <= '0;
		else
			st <= nx;

	assign level      = st.level;
	assign load_pulse = st.load;
endmodule // dsl_strap_sample

// >>> rtl/dsl_lane_detect.sv
// Purpose: Detect one-lane or two-lane activity on the incoming serial link
// Assumes: Second-lane activity indication arrives asynchronously
// Notes:   Change is taken only after it stays stable for a settle time
`timescale 1ns/1ns
module dsl_lane_detect
	import dsl_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic lane_active_pin,
	output logic      two_lane
);
	typedef struct packed {
		logic       s1;
		logic       s2;
		logic [3:0] cnt;
		logic       two;
	} dsl_det_s;

	dsl_det_s st;
	dsl_det_s nx;

	always_comb
	begin
		nx    = st;
		nx.s1 = lane_active_pin;
		nx.s2 = st.s1;
		if (st.s2 == st.two)
			nx.cnt = 4'h0;
		else if (st.cnt == 4'(LANE_STABLE_CYC - 1))
		begin
			nx.two = st.s2;
			nx.cnt = 4'h0;
		end
		else
			nx.cnt = st.cnt + 4'h1;
	end

	always_ff @(posedge clk_sys)
		if (sys_rst)
			st <= '0;
		else
			st <= nx;

	assign two_lane = st.two;
endmodule // dsl_lane_detect

// >>> sim/dsl_board_model.sv
// Purpose: Board side of the block: strap dividers and incoming link activity
// Assumes: Straps are static while the part runs
// Notes:   Link activity arrives with a small skew to the system clock
`timescale 1ns/1ns
module dsl_board_model
(
	input  wire logic [2:0] low_set,
	input  wire logic [2:0] high_set,
	input  wire logic       link_two,
	output logic      [2:0] strap_select_low,
	output logic      [2:0] strap_select_high,
	output logic            lane_active_pin
);
	// ==========================================================
	// Strap levels and link activity
	assign strap_select_low  = low_set;
	assign strap_select_high = high_set;
	assign #3 lane_active_pin = link_two;
endmodule // dsl_board_model

// >>> sim/dsl_strap_lane_cfg_test.sv
// Purpose: Self-checking bench of the strap and lane configuration block
// Assumes: Straps are sampled once per reset
// Notes:   Each strap level therefore gets a reset of its own
`timescale 1ns/1ns
module dsl_strap_lane_cfg_test
	import dsl_pkg::*;
;
	logic        clk_sys  = 1'b0;
	logic        sys_rst  = 1'b1;
	logic [2:0]  low_set  = 3'h0;
	logic [2:0]  high_set = 3'h0;
	logic        link_two = 1'b1;
	logic        cyc      = 1'b0;
	logic        stb      = 1'b0;
	logic        we       = 1'b0;
	logic [7:0]  adr      = 8'h00;
	logic [3:0]  sel      = 4'h0;
	logic [31:0] dat      = 32'h0;
	wire  [2:0]  s_low;
	wire  [2:0]  s_high;
	wire         lane_pin;
	wire  [31:0] rdat;
	wire         ack;
	wire  [9:0]  outs;
	int          fails     = 0;
	int          cmp_count = 0;

	always #2 clk_sys = ~clk_sys;

	dsl_board_model dsl_board_model_inst (.low_set(low_set), .high_set(high_set),
		.link_two(link_two), .strap_select_low(s_low), .strap_select_high(s_high),
		.lane_active_pin(lane_pin));

	dsl_strap_lane_cfg dsl_strap_lane_cfg_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.strap_select_low(s_low), .strap_select_high(s_high), .lane_active_pin(lane_pin),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .bit_map_select(outs[9]),
		.lsb_on_d3_d7(outs[8]), .disp_dual(outs[7]), .disp_swap(outs[6]),
		.disp_replicate(outs[5]), .repeater_en(outs[4]), .back_channel_fast(outs[3]),
		.cable_coax(outs[2]), .rx_two_lane(outs[1]), .config_valid(outs[0]));

	// ==========================================================
	// Expected values
	function automatic logic [5:0] cfg_of(input logic [2:0] l, input logic [2:0] h);
		return {h[1:0], h[2], l[1:0], l[2]};
	endfunction

	function automatic logic [9:0] exp_out(input logic [5:0] c, input logic on,
		input logic [1:0] f, input logic two);
		logic t;
		logic s;
		t = on ? (f == 2'h0 || f == 2'h3) : two;
		s = on && f[1];
		return {c[0], !c[0], !s && !c[2], !s && c[2:1] == 2'h1,
			!s && c[2:1] == 2'h3 && t, c[3], c[5], c[4], t, 1'b1};
	endfunction

	// ==========================================================
	// Compare and bus tasks
	task automatic settle(input int n, input logic [9:0] e);
		int k;
		for (k = 0; k < n && outs !== e; k++)
			@(negedge clk_sys);
		cmp_count++;
		if (outs !== e)
		begin
			fails++;
			$display("wrong value at %0t: outputs %b expected %b", $time, outs, e);
		end
	endtask

	task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value at %0t: read %h expected %h", $time, g, e);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		if (n >= 50)
		begin
			fails++;
			$display("wrong value at %0t: bus ack timeout", $time);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk_rd(q, e);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_straps();
		logic [2:0] l;
		logic [2:0] h;
		for (int i = 0; i < 8; i++)
		begin
			l = i[2:0];
			h = 3'h7 - l;
			@(posedge clk_sys);
			low_set  <= l;
			high_set <= h;
			sys_rst  <= 1'b1;
			repeat (3) @(posedge clk_sys);
			sys_rst <= 1'b0;
			settle(40, exp_out(cfg_of(l, h), 1'b0, 2'h0, 1'b1));
			rd(ADR_STRAP_CFG, {26'h0, cfg_of(l, h)});
		end
	endtask

	task automatic t_hold();
		logic [31:0] q;
		@(posedge clk_sys);
		low_set  <= 3'h0;
		high_set <= 3'h7;
		repeat (30) @(posedge clk_sys);
		settle(1, exp_out(cfg_of(3'h7, 3'h0), 1'b0, 2'h0, 1'b1));
		wb(1'b1, ADR_STRAP_CFG, 32'h37, q);
		settle(2, exp_out(6'h37, 1'b0, 2'h0, 1'b1));
		rd(ADR_STRAP_CFG, 32'h37);
	endtask

	task automatic t_lane();
		@(posedge clk_sys);
		link_two <= 1'b0;
		settle(40, exp_out(6'h37, 1'b0, 2'h0, 1'b0));
		@(posedge clk_sys);
		link_two <= 1'b1;
		settle(40, exp_out(6'h37, 1'b0, 2'h0, 1'b1));
		@(posedge clk_sys);
		link_two <= 1'b0;
		settle(40, exp_out(6'h37, 1'b0, 2'h0, 1'b0));
	endtask

	task automatic t_ovr();
		logic [31:0] q;
		for (int f = 0; f < 4; f++)
		begin
			wb(1'b1, ADR_LANE_OVR, {27'h0, f[1:0], 3'h0}, q);
			settle(2, exp_out(6'h37, 1'b1, f[1:0], 1'b0));
			rd(ADR_LANE_OVR, {27'h0, f[1:0], 3'h0});
		end
		rd(ADR_STATUS, 32'h0000_008B);
		rd(8'h10, 32'h0);
	endtask

	// ==========================================================
	// Verdict
	task automatic print_verdict();
		if (fails == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (3) @(posedge clk_sys);
		t_straps();
		t_hold();
		t_lane();
		t_ovr();
		print_verdict();
	end

	initial
	begin
		#100000;
		fails++;
		$display("wrong value at %0t: watchdog timeout", $time);
		print_verdict();
	end
endmodule // dsl_strap_lane_cfg_test
